// >>> flash_timing_pkg.sv
// Constants and types shared by the flash timing host controller
`default_nettype none
package flash_timing_pkg;

  // ---------------------------------------------------------------
  // Clock rate
  // ---------------------------------------------------------------
  localparam int unsigned CORE_CLK_NS = 40;

  // ---------------------------------------------------------------
  // Times as printed
  // ---------------------------------------------------------------
  localparam int unsigned SOFT_RESTART_RECOVERY_TIME_NS = 40;
  localparam int unsigned ARRAY_RECOVERY_US             = 30;
  localparam int unsigned RESTART_PULSE_WIDTH_NS        = 50;
  localparam int unsigned ERASE_TO_SUSPEND_US           = 150;
  localparam int unsigned PROGRAM_TO_SUSPEND_US         = 5;
  localparam int unsigned SUBSECTOR_TO_SUSPEND_US       = 50;
  localparam int unsigned PROGRAM_SUSPEND_MAX_US        = 25;
  localparam int unsigned ERASE_SUSPEND_MAX_US          = 30;
  // Maximum times in microseconds
  localparam int unsigned STATUS_WRITE_CYCLE_TIME_US     = 8000;
  localparam int unsigned NV_CONFIG_WRITE_CYCLE_TIME_US  = 1000000;
  localparam int unsigned SUBSECTOR_ERASE_TIME_US        = 1000000;
  localparam int unsigned POWER_DOWN_EXIT_TIME_US        = 30;
  localparam int unsigned PROTECTION_REG_PROGRAM_TIME_US = 500;
  localparam int unsigned PASSWORD_PROGRAM_TIME_US       = 800;

  // ---------------------------------------------------------------
  // Derived cycle counts (minimum waits round up)
  // ---------------------------------------------------------------
  localparam int unsigned STBY_CYC  =
    (SOFT_RESTART_RECOVERY_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int unsigned PULSE_CYC =
    (RESTART_PULSE_WIDTH_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int unsigned US_CYC    = 1000 / CORE_CLK_NS;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RESET_ENABLE    = 8'h66;
  localparam logic [7:0] OP_RESET_MEMORY    = 8'h99;
  localparam logic [7:0] OP_BULK_ERASE      = 8'h60;
  localparam logic [7:0] OP_SECTOR_ERASE    = 8'hD8;
  localparam logic [7:0] OP_SUBSECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_WRITE_STATUS    = 8'h01;
  localparam logic [7:0] OP_WRITE_NVCFG     = 8'hB1;
  localparam logic [7:0] OP_PROGRAM_OTP     = 8'h42;
  localparam logic [7:0] OP_SUSPEND         = 8'h75;
  localparam logic [7:0] OP_RESUME          = 8'h7A;

  // ---------------------------------------------------------------
  // Operation that a software reset interrupts
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CTX_STANDBY   = 3'h0,
    CTX_ARRAY     = 3'h1,
    CTX_STATUS_WR = 3'h2,
    CTX_NVCFG_WR  = 3'h3,
    CTX_SUBSECTOR = 3'h4,
    CTX_POWERDOWN = 3'h5,
    CTX_PROT_REG  = 3'h6,
    CTX_PASSWORD  = 3'h7
  } reset_ctx_t;

  // Kind of operation that may later be suspended
  typedef enum logic [1:0] {
    RUN_NONE      = 2'h0,
    RUN_PROGRAM   = 2'h1,
    RUN_SECTOR    = 2'h2,
    RUN_SUBSECTOR = 2'h3
  } run_kind_t;

endpackage
`default_nettype wire

// >>> spi_byte_shifter.sv
// Link-clock SPI byte shifter with handshake crossing to the core clock
`timescale 1ns/1ps
`default_nettype none
module spi_byte_shifter
(
  // Core side
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_req,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_last,
  output logic            o_done,
  // Link side
  input  wire logic       i_link_clk,
  output logic            o_sel_n,
  output logic            o_sck,
  output logic            o_mosi
);

  // ---------------------------------------------------------------
  // Core side toggle and acknowledge synchroniser
  // ---------------------------------------------------------------
  logic req_tgl_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic ack_s3_reg;
  logic [7:0] byte_reg;
  logic       last_reg;
  logic       ack_tgl_reg;

  // Hold byte stable while the link side consumes it
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      req_tgl_reg <= 1'b0;
      byte_reg    <= 8'h00;
      last_reg    <= 1'b0;
      ack_s1_reg  <= 1'b0;
      ack_s2_reg  <= 1'b0;
      ack_s3_reg  <= 1'b0;
    end
    else
    begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      if (i_req)
      begin
        req_tgl_reg <= ~req_tgl_reg;
        byte_reg    <= i_byte;
        last_reg    <= i_last;
      end
    end
  end

  assign o_done = ack_s2_reg ^ ack_s3_reg;

  // ---------------------------------------------------------------
  // Link side: free-running link clock, mode 0 style shift
  // ---------------------------------------------------------------
  logic       req_s1_reg;
  logic       req_s2_reg;
  logic       seen_reg;
  logic [3:0] bit_reg;
  logic       busy_reg;
  logic       sck_reg;
  logic       sel_n_reg;
  logic       mosi_reg;
  wire        new_req = (req_s2_reg != seen_reg) && !busy_reg;

  // Two half-phases per bit: drive data low, then raise clock
  always_ff @(posedge i_link_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      req_s1_reg  <= 1'b0;
      req_s2_reg  <= 1'b0;
      seen_reg    <= 1'b0;
      bit_reg     <= 4'h0;
      busy_reg    <= 1'b0;
      sck_reg     <= 1'b0;
      sel_n_reg   <= 1'b1;
      mosi_reg    <= 1'b0;
      ack_tgl_reg <= 1'b0;
    end
    else
    begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      if (new_req)
      begin
        seen_reg  <= req_s2_reg;
        busy_reg  <= 1'b1;
        bit_reg   <= 4'h0;
        sel_n_reg <= 1'b0;
        mosi_reg  <= byte_reg[7];
      end
      else if (busy_reg)
      begin
        if (!sck_reg)
          sck_reg <= 1'b1;
        else
        begin
          sck_reg <= 1'b0;
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg == 4'h7)
          begin
            busy_reg    <= 1'b0;
            sel_n_reg   <= last_reg;
            ack_tgl_reg <= ~ack_tgl_reg;
          end
          else
            mosi_reg <= byte_reg[3'(3'h6 - bit_reg[2:0])];
        end
      end
    end
  end

  assign o_sel_n = sel_n_reg;
  assign o_sck   = sck_reg;
  assign o_mosi  = mosi_reg;

endmodule
`default_nettype wire

// >>> flash_reset_suspend_timing.sv
// Host controller pacing flash reset recovery and suspend timing
// How it works
// - A reset that hits an array operation holds commands off for at least 30 us.
// - A reset during a status write holds commands off for the status write cycle time.
// - A reset during a config write holds commands off for the config write cycle time.
// - A reset at subsector erase end or suspend holds commands off for subsector erase time.
// - A reset in deep power-down holds commands off for the power-down exit time.
// - A reset during protection register program waits that program time.
// - A reset during password program waits the password program time.
// - The hardware reset pin is held low at least 50 ns.
// - Erase suspend is delayed 150 us after sector erase start or resume.
// - Program suspend is delayed 5 us after program start or resume.
// - Subsector erase suspend is delayed 50 us after its start or resume.
`timescale 1ns/1ps
`default_nettype none
module flash_reset_suspend_timing
#(
  parameter int unsigned STATUS_WRITE_US = flash_timing_pkg::STATUS_WRITE_CYCLE_TIME_US,
  parameter int unsigned NV_CONFIG_US    = flash_timing_pkg::NV_CONFIG_WRITE_CYCLE_TIME_US,
  parameter int unsigned SUBSECTOR_US    = flash_timing_pkg::SUBSECTOR_ERASE_TIME_US,
  parameter int unsigned ERASE_RUN_US    = flash_timing_pkg::ERASE_TO_SUSPEND_US
)
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_link_clk,
  // Command request
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_op,
  input  wire logic       i_cmd_last,
  output logic            o_cmd_ready,
  output logic            o_cmd_reject,
  // Software reset and hardware reset
  input  wire logic       i_soft_reset,
  input  wire logic [2:0] i_reset_ctx,
  input  wire logic       i_hard_reset,
  output logic            o_flash_rst_n,
  output logic            o_recovering,
  // Suspend state
  output logic            o_suspended,
  output logic [1:0]      o_susp_kind,
  // Serial pins
  output logic            o_sel_n,
  output logic            o_sck,
  output logic            o_mosi
);

  // ---------------------------------------------------------------
  // Elaboration checks and timing counts
  // ---------------------------------------------------------------
  localparam int unsigned CW  = 32;
  localparam int unsigned USC = flash_timing_pkg::US_CYC;

  if (STATUS_WRITE_US == 0 || NV_CONFIG_US == 0 || SUBSECTOR_US == 0 || ERASE_RUN_US == 0
      || 64'(NV_CONFIG_US) * USC > 64'hFFFF_FFFF || 64'(SUBSECTOR_US) * USC > 64'hFFFF_FFFF)
  begin : g_bad_timing
    $error("timing parameters out of range");
  end

  localparam logic [CW-1:0] C_STBY = CW'(flash_timing_pkg::STBY_CYC);
  localparam logic [CW-1:0] C_ARR  = CW'(flash_timing_pkg::ARRAY_RECOVERY_US * USC);
  localparam logic [CW-1:0] C_SW   = CW'(64'(STATUS_WRITE_US) * USC);
  localparam logic [CW-1:0] C_NV   = CW'(64'(NV_CONFIG_US) * USC);
  localparam logic [CW-1:0] C_SSE  = CW'(64'(SUBSECTOR_US) * USC);
  localparam logic [CW-1:0] C_PD   = CW'(flash_timing_pkg::POWER_DOWN_EXIT_TIME_US * USC);
  localparam logic [CW-1:0] C_ASP  =
    CW'(flash_timing_pkg::PROTECTION_REG_PROGRAM_TIME_US * USC);
  localparam logic [CW-1:0] C_PW   = CW'(flash_timing_pkg::PASSWORD_PROGRAM_TIME_US * USC);
  localparam logic [CW-1:0] C_ER   = CW'(64'(ERASE_RUN_US) * USC);
  localparam logic [CW-1:0] C_PR   = CW'(flash_timing_pkg::PROGRAM_TO_SUSPEND_US * USC);
  localparam logic [CW-1:0] C_SS   = CW'(flash_timing_pkg::SUBSECTOR_TO_SUSPEND_US * USC);
  localparam logic [CW-1:0] C_PL   = CW'(flash_timing_pkg::PROGRAM_SUSPEND_MAX_US * USC);
  localparam logic [CW-1:0] C_EL   = CW'(flash_timing_pkg::ERASE_SUSPEND_MAX_US * USC);
  localparam logic [3:0]    C_PUL  = 4'(flash_timing_pkg::PULSE_CYC);

  // ---------------------------------------------------------------
  // Controller state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_SEND    = 2'h1,
    ST_RECOVER = 2'h2,
    ST_LATENCY = 2'h3
  } host_state_t;

  host_state_t                 state_reg;
  host_state_t                 state_next;
  logic [CW-1:0]               wait_reg;
  logic [CW-1:0]               wait_next;
  logic [CW-1:0]               run_reg;
  flash_timing_pkg::run_kind_t kind_reg;
  logic                        susp_reg;
  logic [3:0]                  pulse_reg;
  logic                        shift_done;
  logic                        op_reg;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire is_bulk  = (i_cmd_op == flash_timing_pkg::OP_BULK_ERASE);
  wire is_sect  = (i_cmd_op == flash_timing_pkg::OP_SECTOR_ERASE);
  wire is_sub   = (i_cmd_op == flash_timing_pkg::OP_SUBSECTOR_ERASE);
  wire is_susp  = (i_cmd_op == flash_timing_pkg::OP_SUSPEND);
  wire is_res   = (i_cmd_op == flash_timing_pkg::OP_RESUME);
  wire is_prog  = (i_cmd_op == 8'h02);
  wire is_read  = (i_cmd_op == 8'h03) || (i_cmd_op == 8'h0B) || (i_cmd_op == 8'h05)
                  || (i_cmd_op == 8'h6B) || (i_cmd_op == 8'hEB);
  wire is_rst   = (i_cmd_op == flash_timing_pkg::OP_RESET_ENABLE)
                  || (i_cmd_op == flash_timing_pkg::OP_RESET_MEMORY);
  wire is_wblk  = is_bulk || is_sect || is_sub
                  || (i_cmd_op == flash_timing_pkg::OP_WRITE_STATUS)
                  || (i_cmd_op == flash_timing_pkg::OP_WRITE_NVCFG)
                  || (i_cmd_op == flash_timing_pkg::OP_PROGRAM_OTP);
  // Suspend is refused until the operation has run its minimum time
  wire run_short = (kind_reg == flash_timing_pkg::RUN_SECTOR    && run_reg < C_ER)
                || (kind_reg == flash_timing_pkg::RUN_PROGRAM   && run_reg < C_PR)
                || (kind_reg == flash_timing_pkg::RUN_SUBSECTOR && run_reg < C_SS);
  // While suspended, allowed set depends on what was suspended
  wire susp_block = susp_reg && !is_res && !is_rst &&
                    ((kind_reg == flash_timing_pkg::RUN_SECTOR) ? is_wblk : !is_read);
  wire refuse     = susp_block || (is_susp && (susp_reg || run_short));
  wire idle_ok    = (state_reg == ST_IDLE) && (pulse_reg == 4'h0);
  assign o_cmd_ready  = idle_ok && !i_soft_reset && !refuse;
  assign o_cmd_reject = idle_ok && i_cmd_valid && !i_soft_reset && refuse;
  wire   take         = i_cmd_valid && o_cmd_ready;

  // ---------------------------------------------------------------
  // Recovery time chosen by interrupted context
  // ---------------------------------------------------------------
  logic [CW-1:0] rec_cyc;
  always_comb
  begin
    case (flash_timing_pkg::reset_ctx_t'(i_reset_ctx))
      flash_timing_pkg::CTX_STANDBY:   rec_cyc = C_STBY;
      flash_timing_pkg::CTX_ARRAY:     rec_cyc = C_ARR;
      flash_timing_pkg::CTX_STATUS_WR: rec_cyc = C_SW;
      flash_timing_pkg::CTX_NVCFG_WR:  rec_cyc = C_NV;
      flash_timing_pkg::CTX_SUBSECTOR: rec_cyc = C_SSE;
      flash_timing_pkg::CTX_POWERDOWN: rec_cyc = C_PD;
      flash_timing_pkg::CTX_PROT_REG:  rec_cyc = C_ASP;
      flash_timing_pkg::CTX_PASSWORD:  rec_cyc = C_PW;
      default:                         rec_cyc = C_ARR;
    endcase
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    wait_next  = (wait_reg != '0) ? wait_reg - CW'(1) : wait_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (i_soft_reset)
        begin
          state_next = ST_RECOVER;
          wait_next  = rec_cyc;
        end
        else if (take)
          state_next = ST_SEND;
      end
      ST_SEND:
      begin
        if (shift_done)
        begin
          if (susp_reg && op_reg)
          begin
            state_next = ST_LATENCY;
            wait_next  = (kind_reg == flash_timing_pkg::RUN_PROGRAM) ? C_PL : C_EL;
          end
          else
            state_next = ST_IDLE;
        end
      end
      ST_RECOVER:
        if (wait_reg <= CW'(1))
          state_next = ST_IDLE;
      ST_LATENCY:
        if (wait_reg <= CW'(1))
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // State and countdown registers
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg <= ST_IDLE;
      wait_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
    end
  end

  // ---------------------------------------------------------------
  // Running-operation tracker and suspend flag
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      kind_reg <= flash_timing_pkg::RUN_NONE;
      run_reg  <= '0;
      susp_reg <= 1'b0;
      op_reg   <= 1'b0;
    end
    else
    begin
      if (run_reg != '1)
        run_reg <= run_reg + CW'(1);
      if (take)
      begin
        op_reg <= is_susp;
        if (is_susp)
          susp_reg <= 1'b1;
        else if (is_res)
        begin
          susp_reg <= 1'b0;
          run_reg  <= '0;
        end
        else if (is_sect || is_sub || is_prog)
        begin
          run_reg  <= '0;
          kind_reg <= is_sect ? flash_timing_pkg::RUN_SECTOR
                    : is_sub  ? flash_timing_pkg::RUN_SUBSECTOR
                              : flash_timing_pkg::RUN_PROGRAM;
        end
      end
      else if (state_reg == ST_IDLE && i_soft_reset)
      begin
        susp_reg <= 1'b0;
        kind_reg <= flash_timing_pkg::RUN_NONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Hardware reset pulse stretcher
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pulse_reg <= 4'h0;
    else if (i_hard_reset)
      pulse_reg <= C_PUL;
    else if (pulse_reg != 4'h0)
      pulse_reg <= pulse_reg - 4'h1;
  end

  assign o_flash_rst_n = (pulse_reg == 4'h0);
  assign o_recovering  = (state_reg == ST_RECOVER);
  assign o_suspended   = susp_reg;
  assign o_susp_kind   = kind_reg;

  // ---------------------------------------------------------------
  // Serial shifter on the link clock
  // ---------------------------------------------------------------
  spi_byte_shifter u_shift
  (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_req      (take),
    .i_byte     (i_cmd_op),
    .i_last     (i_cmd_last),
    .o_done     (shift_done),
    .i_link_clk (i_link_clk),
    .o_sel_n    (o_sel_n),
    .o_sck      (o_sck),
    .o_mosi     (o_mosi)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_arr_hold;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state_reg == ST_IDLE && i_soft_reset && i_reset_ctx == 3'h1)
      |=> o_recovering [*8];
  endproperty
  a_arr_hold: assert property (p_arr_hold) else $error("array recovery too short");

  property p_stby;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state_reg == ST_IDLE && i_soft_reset && i_reset_ctx == 3'h0) |=> ##[1:2] !o_recovering;
  endproperty
  a_stby: assert property (p_stby) else $error("standby recovery not short");

  property p_quiet;
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_recovering |-> !o_cmd_ready;
  endproperty
  a_quiet: assert property (p_quiet) else $error("command ready during recovery");

  property p_pulse;
    @(posedge i_core_clk) disable iff (!i_rstn)
    $fell(o_flash_rst_n) |=> !o_flash_rst_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too short");

  property p_erase_run;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (o_cmd_ready && i_cmd_valid && is_susp) |-> !(kind_reg == 2'h2 && run_reg < C_ER);
  endproperty
  a_erase_run: assert property (p_erase_run) else $error("erase suspended early");

  property p_prog_run;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (o_cmd_ready && i_cmd_valid && is_susp) |-> !(kind_reg == 2'h1 && run_reg < C_PR);
  endproperty
  a_prog_run: assert property (p_prog_run) else $error("program suspended early");

  property p_sub_run;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (o_cmd_ready && i_cmd_valid && is_susp) |-> !(kind_reg == 2'h3 && run_reg < C_SS);
  endproperty
  a_sub_run: assert property (p_sub_run) else $error("subsector suspended early");

  property p_susp_blk;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (o_suspended && kind_reg == 2'h2 && i_cmd_valid && is_wblk) |-> !o_cmd_ready;
  endproperty
  a_susp_blk: assert property (p_susp_blk) else $error("blocked command in erase suspend");

  property p_susp_read;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (o_suspended && kind_reg == 2'h1 && i_cmd_valid && !is_read && !is_res && !is_rst)
      |-> !o_cmd_ready;
  endproperty
  a_susp_read: assert property (p_susp_read) else $error("non-read in program suspend");

endmodule
`default_nettype wire

// >>> flash_device_model.sv
// Behavioural flash device that receives serial command bytes
`timescale 1ns/1ps
`default_nettype none
module flash_device_model
(
  // Serial pins
  input  wire logic i_sel_n,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  // Observation
  output logic [7:0] o_last_op,
  output int         o_op_count,
  output logic       o_bulk_seen
);
  logic [7:0] shift_reg;
  int         bit_cnt;

  initial
  begin
    o_last_op   = 8'h00;
    o_op_count  = 0;
    o_bulk_seen = 1'b0;
    bit_cnt     = 0;
  end

  // Deselect frames a new command
  always @(posedge i_sel_n)
  begin
    bit_cnt = 0;
  end

  // Mode 0 capture, MSB first, decode on each whole byte
  always @(posedge i_sck)
  begin
    if (i_sel_n === 1'b0)
    begin
      shift_reg = {shift_reg[6:0], i_mosi};
      bit_cnt++;
      if (bit_cnt == 8)
      begin
        o_last_op = shift_reg;
        o_op_count++;
        bit_cnt = 0;
        if (shift_reg === 8'h60)
          o_bulk_seen = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> flash_reset_suspend_timing_bench.sv
// Self-checking bench for the flash reset and suspend host controller
`timescale 1ns/1ps
`default_nettype none
module flash_reset_suspend_timing_bench;
  localparam int P = 2;
  localparam int US = flash_timing_pkg::US_CYC;
  localparam int CK = flash_timing_pkg::CORE_CLK_NS;
  logic clk, link, rstn, valid, last, srst, hrst;
  logic [7:0] op;
  logic [2:0] ctx;
  logic ready, reject, frst_n, recovering, susp, sel_n, sck, mosi, bulk;
  logic [1:0] kind;
  logic [7:0] last_op;
  int op_count, err_total, total_checks, cnt, i;
  logic [7:0] reads [5] = '{8'h03, 8'h0B, 8'h05, 8'h6B, 8'hEB};

  flash_reset_suspend_timing #(.STATUS_WRITE_US(P), .NV_CONFIG_US(P), .SUBSECTOR_US(P),
    .ERASE_RUN_US(P)) DUT (.i_core_clk(clk), .i_rstn(rstn), .i_link_clk(link),
    .i_cmd_valid(valid), .i_cmd_op(op), .i_cmd_last(last), .o_cmd_ready(ready),
    .o_cmd_reject(reject), .i_soft_reset(srst), .i_reset_ctx(ctx), .i_hard_reset(hrst),
    .o_flash_rst_n(frst_n), .o_recovering(recovering), .o_suspended(susp),
    .o_susp_kind(kind), .o_sel_n(sel_n), .o_sck(sck), .o_mosi(mosi));
  flash_device_model dev (.i_sel_n(sel_n), .i_sck(sck), .i_mosi(mosi),
    .o_last_op(last_op), .o_op_count(op_count), .o_bulk_seen(bulk));

  // Clocks, unrelated in phase
  always #20 clk = ~clk;
  always #16 link = ~link;

  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait step
  task automatic bump(inout int n);
    n++;
    if (n > 40000)
    begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1)
    begin
      @(negedge clk);
      bump(n);
    end
    @(posedge clk);
  endtask

  // One command byte, held until taken or refused
  task automatic try_op(input logic [7:0] code, input logic rej);
    int n, n0;
    n = 0;
    n0 = op_count;
    @(posedge clk);
    valid <= 1'b1;
    op <= code;
    @(negedge clk);
    while (ready !== 1'b1 && reject !== 1'b1)
    begin
      @(negedge clk);
      bump(n);
    end
    chk(reject, rej);
    @(posedge clk);
    valid <= 1'b0;
    if (!rej)
    begin
      while (op_count != n0 + 1)
      begin
        @(negedge clk);
        bump(n);
      end
      chk(last_op, code);
    end
  endtask

  // Recovery length expected for each interrupted operation
  function automatic int rec_cyc(input int c);
    case (c)
      0: return flash_timing_pkg::STBY_CYC;
      1: return flash_timing_pkg::ARRAY_RECOVERY_US * US;
      5: return flash_timing_pkg::POWER_DOWN_EXIT_TIME_US * US;
      6: return flash_timing_pkg::PROTECTION_REG_PROGRAM_TIME_US * US;
      7: return flash_timing_pkg::PASSWORD_PROGRAM_TIME_US * US;
      default: return P * US;
    endcase
  endfunction

  task automatic soft_rst(input int c);
    int n;
    n = 0;
    cnt = 0;
    wait_ready();
    srst <= 1'b1;
    ctx <= c[2:0];
    @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    while (recovering === 1'b1)
    begin
      cnt++;
      chk(ready, 0);
      @(negedge clk);
      bump(n);
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {clk, link, rstn, valid, srst, hrst, op, ctx} = '0;
    last = 1'b1;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'h2C53));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    try_op(8'h60, 1'b0);
    chk(bulk, 1);
    for (i = 0; i < 8; i++)
    begin
      soft_rst(i);
      chk(cnt, rec_cyc(i));
    end
    wait_ready();
    hrst <= 1'b1;
    @(posedge clk);
    hrst <= 1'b0;
    cnt = 0;
    repeat (8) @(negedge clk) cnt += (frst_n === 1'b0);
    chk(cnt, flash_timing_pkg::PULSE_CYC);
    chk(cnt * CK >= flash_timing_pkg::RESTART_PULSE_WIDTH_NS, 1);
    repeat (4) try_op(reads[$urandom_range(0, 4)], 1'b0);
    try_op(8'hD8, 1'b0);
    try_op(8'h75, 1'b1);
    repeat (P * US + 10) @(posedge clk);
    try_op(8'h75, 1'b0);
    chk({susp, kind}, 3'h6);
    try_op(8'h20, 1'b1);
    try_op(8'h01, 1'b1);
    try_op(8'h03, 1'b0);
    try_op(8'h7A, 1'b0);
    try_op(8'h75, 1'b1);
    try_op(8'h02, 1'b0);
    try_op(8'h75, 1'b1);
    repeat (flash_timing_pkg::PROGRAM_TO_SUSPEND_US * US + 10) @(posedge clk);
    try_op(8'h75, 1'b0);
    chk({susp, kind}, 3'h5);
    try_op(8'hD8, 1'b1);
    try_op(8'h0B, 1'b0);
    try_op(8'h7A, 1'b0);
    try_op(8'h20, 1'b0);
    try_op(8'h75, 1'b1);
    repeat (flash_timing_pkg::SUBSECTOR_TO_SUSPEND_US * US + 10) @(posedge clk);
    try_op(8'h75, 1'b0);
    chk({susp, kind}, 3'h7);
    try_op(8'h02, 1'b1);
    try_op(8'h7A, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
